/* include/esr_pkg.sv */
// constants and answer tags for the event status reporting block
package esr_pkg;
   // ------------------------------------------------------------
   // event latch field positions
   // ------------------------------------------------------------
   localparam int unsigned BIT_OPC_DONE = 0;
   localparam int unsigned BIT_QUERY_ERR = 2;
   localparam int unsigned BIT_DEVICE_ERR = 3;
   localparam int unsigned BIT_EXEC_ERR = 4;
   localparam int unsigned BIT_CMD_ERR = 5;
   localparam logic [7:0] EVENT_IMPL_MASK = 8'h3d;
   // ------------------------------------------------------------
   // status byte field positions
   // ------------------------------------------------------------
   localparam int unsigned STB_BIT_QUESTIONABLE_SUMMARY_BIT = 3;
   localparam int unsigned STB_BIT_ESB = 5;
   localparam int unsigned STB_BIT_MSS = 6;
   // ------------------------------------------------------------
   // reset values and answer codes
   // ------------------------------------------------------------
   localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
   localparam logic [7:0] EVENT_LATCH_RESET = 8'h00;
   localparam logic [7:0] SRQ_MASK_RESET = 8'h00;
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_ONE = 8'h31;
   localparam logic [9:0] ERR_CLASS_STEP = 10'h064;
   localparam int unsigned IDN_LAST_FIELD = 4;
   // answer tags
   typedef enum logic [2:0] {
      TAG_LATCH, TAG_MASK, TAG_OPC, TAG_IDN, TAG_SRQ_MASK, TAG_STB
   } resp_tag_t;
endpackage

/* hw/event_status_reporting.sv */
// status reporting core: event latch, masks, completion tracking, status byte
module event_status_reporting #(
   parameter logic [31:0] MAKER_CODE = 32'h0000_00a1, // arbitrary value
   parameter logic [31:0] MODEL_CODE = 32'h0000_00b2, // arbitrary value, holds rating
   parameter logic [31:0] CAL_DATE_BCD = 32'h0101_2000, // MMDDYYYY in bcd
   parameter logic [31:0] SERIAL_BCD = 32'h0000_0001, // six bcd digits
   parameter logic [31:0] FW_REV = 32'h0000_0100, // arbitrary value
   parameter int unsigned NUM_PROC = 3
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_err_valid,
   input wire logic [9:0] i_err_code,
   input wire logic i_reg_err,
   input wire logic i_questionable_summary_bit_reg_bit,
   input wire logic i_cmd_opc,
   input wire logic i_qry_opc,
   input wire logic i_qry_latch,
   input wire logic i_qry_mask,
   input wire logic i_cmd_mask,
   input wire logic [7:0] i_mask_data,
   input wire logic i_cmd_srq_mask,
   input wire logic [7:0] i_srq_mask_data,
   input wire logic i_qry_srq_mask,
   input wire logic i_qry_stb,
   input wire logic i_qry_idn,
   input wire logic i_cmd_cls,
   input wire logic i_cmd_wai,
   input wire logic i_serial_poll,
   input wire logic i_cmds_pending,
   input wire logic [NUM_PROC-1:0] i_proc_idle,
   input wire logic i_output_settled,
   input wire logic [7:0] i_stb_other,
   output logic o_cmd_ready,
   output logic o_resp_valid,
   output logic [2:0] o_resp_tag,
   output logic [31:0] o_resp_data,
   output logic [7:0] o_event_latch,
   output logic [7:0] o_status_byte,
   output logic o_service_request
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // error class is the hundreds digit; class 0 and 5+ raise nothing here
   function automatic logic [7:0] err_bits(input logic [9:0] code);
      logic [7:0] b;
      b = 8'h00;
      if (code >= esr_pkg::ERR_CLASS_STEP * 10'd1 && code < esr_pkg::ERR_CLASS_STEP * 10'd2)
         b[esr_pkg::BIT_CMD_ERR] = 1'b1;
      if (code >= esr_pkg::ERR_CLASS_STEP * 10'd2 && code < esr_pkg::ERR_CLASS_STEP * 10'd3)
         b[esr_pkg::BIT_EXEC_ERR] = 1'b1;
      if (code >= esr_pkg::ERR_CLASS_STEP * 10'd3 && code < esr_pkg::ERR_CLASS_STEP * 10'd4)
         b[esr_pkg::BIT_DEVICE_ERR] = 1'b1;
      if (code >= esr_pkg::ERR_CLASS_STEP * 10'd4 && code < esr_pkg::ERR_CLASS_STEP * 10'd5)
         b[esr_pkg::BIT_QUERY_ERR] = 1'b1;
      return b;
   endfunction

   localparam int unsigned SW = NUM_PROC + 1;

   // ------------------------------------------------------------
   // synchronisers for idle lines from the other processors and the output settled line
   // ------------------------------------------------------------
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   logic [SW-1:0] sync3_r;
   logic [SW-1:0] idle_r;
   logic [SW-1:0] idle_nxt;
   logic [SW-1:0] idle_raw;

   assign idle_raw = {i_output_settled, i_proc_idle};

   // a change counts only once stages two and three agree
   assign idle_nxt = (sync2_r == sync3_r) ? sync3_r : idle_r;

   // three-stage capture, bit-wise
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         idle_r <= '0;
      end
      else
      begin
         sync1_r <= idle_raw;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         idle_r <= idle_nxt;
      end
   end

   // ------------------------------------------------------------
   // completion tracking
   // ------------------------------------------------------------
   logic opc_armed_r;
   logic opc_armed_nxt;
   logic wai_hold_r;
   logic wai_hold_nxt;
   logic all_done;
   logic idn_busy;

   // everything before has run, processors idle, output level settled
   assign all_done = !i_cmds_pending && (&idle_r);

   // arming clears the flag, but nothing here gates command intake
   assign opc_armed_nxt = i_cmd_opc ? 1'b1 :
                          (i_cmd_cls || all_done) ? 1'b0 : opc_armed_r;
   assign wai_hold_nxt = i_cmd_wai ? 1'b1 :
                         all_done ? 1'b0 : wai_hold_r;

   // only the wait hold and an identity answer stall intake
   assign o_cmd_ready = !wai_hold_r && !idn_busy;

   // completion state
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         opc_armed_r <= 1'b0;
         wai_hold_r <= 1'b0;
      end
      else
      begin
         opc_armed_r <= opc_armed_nxt;
         wai_hold_r <= wai_hold_nxt;
      end
   end

   // ------------------------------------------------------------
   // event latch and masks
   // ------------------------------------------------------------
   logic [7:0] latch_r;
   logic [7:0] latch_nxt;
   logic [7:0] mask_r;
   logic [7:0] mask_nxt;
   logic [7:0] srq_mask_r;
   logic [7:0] srq_mask_nxt;
   logic [7:0] set_bits;
   logic [7:0] dev_bit;
   logic [7:0] opc_bit;
   logic clr_latch;

   assign dev_bit = (i_reg_err && i_questionable_summary_bit_reg_bit) ?
                    (8'h01 << esr_pkg::BIT_DEVICE_ERR) : 8'h00;
   assign opc_bit = (opc_armed_r && all_done && !i_cmd_opc) ?
                    (8'h01 << esr_pkg::BIT_OPC_DONE) : 8'h00;
   assign set_bits = ((i_err_valid ? err_bits(i_err_code) : 8'h00)
                     | dev_bit | opc_bit) & esr_pkg::EVENT_IMPL_MASK;
   // a latch query dropped during the identity stream must not lose events
   assign clr_latch = (i_qry_latch && !idn_busy) || i_cmd_cls;

   // set wins over clear so an event in the read cycle survives
   assign latch_nxt = (clr_latch ? 8'h00 :
                      (i_cmd_opc ? (latch_r & ~(8'h01 << esr_pkg::BIT_OPC_DONE))
                       : latch_r)) | set_bits;
   // any 0..255 is taken; cls leaves the masks alone
   assign mask_nxt = i_cmd_mask ? i_mask_data : mask_r;
   assign srq_mask_nxt = i_cmd_srq_mask ? i_srq_mask_data : srq_mask_r;

   // latch and mask storage
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         latch_r <= esr_pkg::EVENT_LATCH_RESET;
         mask_r <= esr_pkg::EVENT_MASK_RESET;
         srq_mask_r <= esr_pkg::SRQ_MASK_RESET;
      end
      else
      begin
         latch_r <= latch_nxt;
         mask_r <= mask_nxt;
         srq_mask_r <= srq_mask_nxt;
      end
   end

   assign o_event_latch = latch_r;

   // ------------------------------------------------------------
   // status byte and service request
   // ------------------------------------------------------------
   logic event_summary_bit;
   logic [7:0] stb_low;
   logic master_summary_bit;
   logic rqs_r;
   logic rqs_nxt;
   logic mss_q_r;

   // unused positions of the latch are zero, so their mask bits do nothing
   assign event_summary_bit = |(latch_r & mask_r & esr_pkg::EVENT_IMPL_MASK);
   assign stb_low = (i_stb_other & ~(8'h01 << esr_pkg::STB_BIT_ESB)
                     & ~(8'h01 << esr_pkg::STB_BIT_MSS))
                    | (event_summary_bit ? (8'h01 << esr_pkg::STB_BIT_ESB) : 8'h00);
   // bit 6 of the request mask cannot take part
   assign master_summary_bit = |(stb_low & srq_mask_r);
   assign o_status_byte = stb_low | (master_summary_bit ? (8'h01 << esr_pkg::STB_BIT_MSS) : 8'h00);

   // request raised on a new summary, dropped by serial poll or cls
   assign rqs_nxt = (master_summary_bit && !mss_q_r) ? 1'b1 :
                    (i_serial_poll || i_cmd_cls) ? 1'b0 : rqs_r;
   assign o_service_request = rqs_r;

   // service request state
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         rqs_r <= 1'b0;
         mss_q_r <= 1'b0;
      end
      else
      begin
         rqs_r <= rqs_nxt;
         mss_q_r <= master_summary_bit;
      end
   end

   // ------------------------------------------------------------
   // answers
   // ------------------------------------------------------------
   logic [2:0] idn_idx_r;
   logic [2:0] idn_idx_nxt;
   logic idn_run_r;
   logic idn_run_nxt;
   logic resp_valid_nxt;
   logic [2:0] resp_tag_nxt;
   logic [31:0] resp_data_nxt;
   logic [31:0] idn_word;

   assign idn_busy = idn_run_r;
   // identity fields leave in fixed order
   assign idn_word = (idn_idx_r == 3'd0) ? MAKER_CODE :
                     (idn_idx_r == 3'd1) ? MODEL_CODE :
                     (idn_idx_r == 3'd2) ? CAL_DATE_BCD :
                     (idn_idx_r == 3'd3) ? SERIAL_BCD : FW_REV;
   assign idn_run_nxt = i_qry_idn ? 1'b1 :
                        (idn_idx_r == 3'(esr_pkg::IDN_LAST_FIELD)) ? 1'b0 : idn_run_r;
   assign idn_idx_nxt = idn_run_r ? 3'(idn_idx_r + 3'd1) : 3'd0;

   // one query per cycle assumed; identity stream blocks the rest
   always_comb
   begin
      resp_valid_nxt = 1'b1;
      resp_tag_nxt = esr_pkg::TAG_LATCH;
      resp_data_nxt = 32'h0000_0000;
      if (idn_run_r)
      begin
         resp_tag_nxt = esr_pkg::TAG_IDN;
         resp_data_nxt = idn_word;
      end
      else if (i_qry_latch)
         resp_data_nxt = {24'h000000, latch_r};
      else if (i_qry_mask)
      begin
         resp_tag_nxt = esr_pkg::TAG_MASK;
         resp_data_nxt = {24'h000000, mask_r};
      end
      else if (i_qry_opc)
      begin
         resp_tag_nxt = esr_pkg::TAG_OPC;
         resp_data_nxt = {24'h000000, opc_armed_r ? esr_pkg::ASCII_ZERO
                                                  : esr_pkg::ASCII_ONE};
      end
      else if (i_qry_srq_mask)
      begin
         resp_tag_nxt = esr_pkg::TAG_SRQ_MASK;
         resp_data_nxt = {24'h000000, srq_mask_r};
      end
      else if (i_qry_stb)
      begin
         resp_tag_nxt = esr_pkg::TAG_STB;
         resp_data_nxt = {24'h000000, o_status_byte};
      end
      else
         resp_valid_nxt = 1'b0;
   end

   // answer registers
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         o_resp_valid <= 1'b0;
         o_resp_tag <= 3'd0;
         o_resp_data <= 32'h0000_0000;
         idn_run_r <= 1'b0;
         idn_idx_r <= 3'd0;
      end
      else
      begin
         o_resp_valid <= resp_valid_nxt;
         o_resp_tag <= resp_tag_nxt;
         o_resp_data <= resp_data_nxt;
         idn_run_r <= idn_run_nxt;
         idn_idx_r <= idn_idx_nxt;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   property p_cmd_err;
      i_err_valid && i_err_code >= 10'd100 && i_err_code < 10'd200
         |=> latch_r[5];
   endproperty
   a_cmd_err: assert property (p_cmd_err) else $error("command error not latched");
   property p_exec_err;
      i_err_valid && i_err_code >= 10'd200 && i_err_code < 10'd300
         |=> latch_r[4];
   endproperty
   a_exec_err: assert property (p_exec_err) else $error("execution error not latched");
   property p_dev_err;
      (i_err_valid && i_err_code >= 10'd300 && i_err_code < 10'd400)
         || (i_reg_err && i_questionable_summary_bit_reg_bit) |=> latch_r[3];
   endproperty
   a_dev_err: assert property (p_dev_err) else $error("device error not latched");
   property p_query_err;
      i_err_valid && i_err_code >= 10'd400 && i_err_code < 10'd500
         |=> latch_r[2];
   endproperty
   a_query_err: assert property (p_query_err) else $error("query error not latched");
   property p_read_clear;
      i_qry_latch && !idn_run_r && !i_err_valid && !i_reg_err && !opc_armed_r
         |=> o_resp_data[7:0] == $past(latch_r) && latch_r == 8'h00;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("latch read wrong");
   property p_mask_read;
      i_qry_mask && !idn_run_r && !i_qry_latch && !i_cmd_mask
         |=> o_resp_data[7:0] == mask_r && $stable(mask_r);
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read wrong");
   property p_summary;
      o_status_byte[5] == |(latch_r & mask_r);
   endproperty
   a_summary: assert property (p_summary) else $error("summary bit wrong");
   property p_opc_clear;
      i_cmd_opc |=> !latch_r[0] && opc_armed_r;
   endproperty
   a_opc_clear: assert property (p_opc_clear) else $error("arm did not clear flag");
   property p_opc_done;
      opc_armed_r && !i_cmd_opc && !i_cmd_cls && all_done |=> latch_r[0] && !opc_armed_r;
   endproperty
   a_opc_done: assert property (p_opc_done) else $error("completion not flagged");
   property p_unused_zero;
      latch_r[7:6] == 2'b00 && !latch_r[1];
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");
   property p_sticky;
      latch_r[5] && !i_qry_latch && !i_cmd_cls |=> latch_r[5];
   endproperty
   a_sticky: assert property (p_sticky) else $error("event bit lost");
   property p_wai_hold;
      i_cmd_wai ##1 !all_done [*2] |-> !o_cmd_ready;
   endproperty
   a_wai_hold: assert property (p_wai_hold) else $error("wait did not hold");
endmodule

/* dv/gpib_ctl_model.sv */
// controller-side model: issues command and query pulses to the block
module gpib_ctl_model (
   input wire logic i_core_clk,
   output logic [11:0] o_cmd,
   output logic [7:0] o_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic armed_r = 1'b0;
   initial
   begin
      o_cmd = 12'h000;
      o_data = 8'h00;
   end
   // -----------------------------------------------------------
   // one pulse per command, data held with it
   // -----------------------------------------------------------
   // released data is inverted so a stale value never looks valid
   task automatic pulse(input int c, input logic [7:0] d);
      @(posedge i_core_clk);
      #1;
      o_cmd[c] = 1'b1;
      o_data = d;
      @(posedge i_core_clk);
      #1;
      o_cmd[c] = 1'b0;
      o_data = ~d;
   endtask
   // a completion query is always preceded by an arm since the last clear
   task automatic send(input int c, input logic [7:0] d);
      if (c == 1 && armed_r !== 1'b1)
      begin
         pulse(0, 8'h00);
      end
      pulse(c, d);
      if (c == 0)
      begin
         armed_r = 1'b1;
      end
      if (c == 9)
      begin
         armed_r = 1'b0;
      end
   endtask
endmodule

/* dv/tb.sv */
// self-checking bench for the event status reporting block
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   // -----------------------------------------------------------
   // command slots and identity words
   // -----------------------------------------------------------
   localparam int k_arm = 0;
   localparam int k_q_done = 1;
   localparam int k_q_latch = 2;
   localparam int k_q_mask = 3;
   localparam int k_w_mask = 4;
   localparam int k_w_srq = 5;
   localparam int k_q_srq = 6;
   localparam int k_q_status = 7;
   localparam int k_q_id = 8;
   localparam int k_clear = 9;
   localparam int k_wait = 10;
   localparam int k_poll = 11;
   // maker, model and firmware words are arbitrary
   localparam logic [31:0] id_w [5] = '{32'h0000_0a11, 32'h0000_0b22,
      32'h0930_2001, 32'h0012_3456, 32'h0000_0401};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic err_valid = 1'b0;
   logic [9:0] err_code = 10'h000;
   logic reg_err = 1'b0;
   logic questionable_summary_bit_bit = 1'b0;
   logic pending = 1'b0;
   logic [2:0] proc_idle = 3'h7;
   logic settled = 1'b1;
   logic [7:0] other_bits = 8'h00;
   logic [11:0] cmd;
   logic [7:0] data;
   logic cmd_ready;
   logic resp_valid;
   logic service_req;
   logic [2:0] resp_tag;
   logic [31:0] resp_data;
   logic [7:0] event_latch;
   logic [7:0] status_byte;
   logic [7:0] exp_l;
   int n_fail = 0;
   int cmp_count = 0;
   gpib_ctl_model gpib_ctl_model_i (
      .i_core_clk(clk),
      .o_cmd(cmd),
      .o_data(data)
   );
   event_status_reporting #(
      .MAKER_CODE(id_w[0]),
      .MODEL_CODE(id_w[1]),
      .CAL_DATE_BCD(id_w[2]),
      .SERIAL_BCD(id_w[3]),
      .FW_REV(id_w[4]),
      .NUM_PROC(3)
   ) event_status_reporting_i (
      .i_core_clk(clk),
      .i_rst_n(rst_n),
      .i_err_valid(err_valid),
      .i_err_code(err_code),
      .i_reg_err(reg_err),
      .i_questionable_summary_bit_reg_bit(questionable_summary_bit_bit),
      .i_cmd_opc(cmd[0]),
      .i_qry_opc(cmd[1]),
      .i_qry_latch(cmd[2]),
      .i_qry_mask(cmd[3]),
      .i_cmd_mask(cmd[4]),
      .i_mask_data(data),
      .i_cmd_srq_mask(cmd[5]),
      .i_srq_mask_data(data),
      .i_qry_srq_mask(cmd[6]),
      .i_qry_stb(cmd[7]),
      .i_qry_idn(cmd[8]),
      .i_cmd_cls(cmd[9]),
      .i_cmd_wai(cmd[10]),
      .i_serial_poll(cmd[11]),
      .i_cmds_pending(pending),
      .i_proc_idle(proc_idle),
      .i_output_settled(settled),
      .i_stb_other(other_bits),
      .o_cmd_ready(cmd_ready),
      .o_resp_valid(resp_valid),
      .o_resp_tag(resp_tag),
      .o_resp_data(resp_data),
      .o_event_latch(event_latch),
      .o_status_byte(status_byte),
      .o_service_request(service_req)
   );
   // 100 MHz core clock
   initial
   begin
      forever #5 clk = ~clk;
   end
   // -----------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------
   // inputs always move 1 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic raise(input logic [9:0] code);
      cyc(1);
      err_valid = 1'b1;
      err_code = code;
      cyc(1);
      err_valid = 1'b0;
      err_code = ~code;
   endtask
   task automatic answer(input logic [2:0] tag, input logic [31:0] d);
      `CHK(resp_valid, 1'b1)
      `CHK(resp_tag, tag)
      `CHK(resp_data, d)
   endtask
   task automatic ask(input int c, input logic [2:0] tag, input logic [31:0] d);
      gpib_ctl_model_i.send(c, 8'h00);
      answer(tag, d);
   endtask
   task automatic tend(input string s);
      $display("test %s finished", s);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog, far beyond the hundred-odd cycles the tests need
   initial
   begin
      #100000;
      n_fail++;
      complete_run();
   end
   // -----------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------
   initial
   begin
      cyc(20);
      rst_n = 1'b1;
      `CHK(event_latch, 8'h00)
      `CHK(status_byte, 8'h00)
      ask(k_q_mask, 3'h1, 32'h0000_0000);
      tend("reset");
      exp_l = 8'h00;
      for (int k = 1; k <= 4; k++)
      begin
         raise(10'(k * 100 + 50));
         exp_l[6 - k] = 1'b1;
         `CHK(event_latch, exp_l)
      end
      ask(k_q_latch, 3'h0, 32'h0000_003c);
      `CHK(event_latch, 8'h00)
      reg_err = 1'b1;
      cyc(1);
      reg_err = 1'b0;
      `CHK(event_latch, 8'h00)
      questionable_summary_bit_bit = 1'b1;
      reg_err = 1'b1;
      cyc(1);
      reg_err = 1'b0;
      questionable_summary_bit_bit = 1'b0;
      cyc(3);
      `CHK(event_latch, 8'h08)
      tend("errors");
      gpib_ctl_model_i.send(k_w_mask, 8'hc2);
      `CHK(status_byte[5], 1'b0)
      ask(k_q_mask, 3'h1, 32'h0000_00c2);
      `CHK(event_latch, 8'h08)
      gpib_ctl_model_i.send(k_w_mask, 8'h08);
      `CHK(status_byte, 8'h20)
      gpib_ctl_model_i.send(k_w_srq, 8'h28);
      cyc(2);
      `CHK(status_byte, 8'h60)
      `CHK(service_req, 1'b1)
      ask(k_q_srq, 3'h4, 32'h0000_0028);
      ask(k_q_status, 3'h5, 32'h0000_0060);
      gpib_ctl_model_i.send(k_clear, 8'h00);
      cyc(1);
      `CHK(event_latch, 8'h00)
      `CHK(status_byte, 8'h00)
      ask(k_q_mask, 3'h1, 32'h0000_0008);
      other_bits = 8'h08;
      cyc(2);
      `CHK(status_byte, 8'h48)
      `CHK(service_req, 1'b1)
      other_bits = 8'h00;
      gpib_ctl_model_i.send(k_poll, 8'h00);
      cyc(1);
      `CHK(service_req, 1'b0)
      tend("masks");
      pending = 1'b1;
      proc_idle = 3'h3;
      settled = 1'b0;
      gpib_ctl_model_i.send(k_arm, 8'h00);
      ask(k_q_done, 3'h2, 32'h0000_0030);
      `CHK(cmd_ready, 1'b1)
      pending = 1'b0;
      cyc(8);
      `CHK(event_latch[0], 1'b0)
      proc_idle = 3'h7;
      cyc(8);
      `CHK(event_latch[0], 1'b0)
      settled = 1'b1;
      for (int i = 0; i < 12 && event_latch[0] !== 1'b1; i++)
         cyc(1);
      `CHK(event_latch[0], 1'b1)
      pending = 1'b1;
      gpib_ctl_model_i.send(k_arm, 8'h00);
      `CHK(event_latch[0], 1'b0)
      pending = 1'b0;
      for (int i = 0; i < 12 && event_latch[0] !== 1'b1; i++)
         cyc(1);
      ask(k_q_done, 3'h2, 32'h0000_0031);
      ask(k_q_latch, 3'h0, 32'h0000_0001);
      tend("completion");
      pending = 1'b1;
      gpib_ctl_model_i.send(k_wait, 8'h00);
      cyc(4);
      `CHK(cmd_ready, 1'b0)
      pending = 1'b0;
      for (int i = 0; i < 12 && cmd_ready !== 1'b1; i++)
         cyc(1);
      `CHK(cmd_ready, 1'b1)
      tend("wait");
      gpib_ctl_model_i.send(k_q_id, 8'h00);
      for (int w = 0; w < 5; w++)
      begin
         cyc(1);
         answer(3'h3, id_w[w]);
      end
      tend("identity");
      complete_run();
   end
endmodule
